/* File: rtl/sprc_pkg.sv */
/*
  shared constants of the self polling run control: register offsets,
  control field positions, reset values and the machine's states.
  assumes a 32-bit apb with byte addresses and one word per register.
*/
package sprc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] SPRC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SPRC_OFF_MASK   = 8'h04;
  localparam logic [7:0] SPRC_OFF_EXTCMD = 8'h08;
  localparam logic [7:0] SPRC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] SPRC_OFF_ACCEPT = 8'h10;
  // ==========================================================
  // control register fields
  localparam int SPRC_B_OPSEL     = 0;
  localparam int SPRC_B_SLEEP     = 1;
  localparam int SPRC_B_MODE_LO   = 2;
  localparam int SPRC_B_DUAL      = 4;
  localparam int SPRC_B_MODTYPE   = 5;
  localparam int SPRC_B_RET_END   = 6;
  localparam int SPRC_B_PWU_EN    = 7;
  localparam int SPRC_B_FR_KEEP   = 8;
  localparam int SPRC_B_EXT_PROC  = 9;
  localparam int SPRC_B_END_RST_A = 10;
  localparam int SPRC_B_TO_RST_A  = 11;
  localparam int SPRC_B_FIFO_FRM  = 12;
  localparam int SPRC_B_HOLD      = 13;
  localparam int SPRC_CTRL_W      = 14;
  localparam logic [SPRC_CTRL_W-1:0] SPRC_CTRL_RST = 14'h0002;
  // ==========================================================
  // mask and external command fields
  localparam int SPRC_M_WAKE  = 0;
  localparam int SPRC_M_FRAME = 1;
  localparam int SPRC_M_MID   = 2;
  localparam int SPRC_M_END   = 3;
  localparam logic [3:0] SPRC_MASK_RST = 4'h0;
  localparam int SPRC_X_TO    = 0;
  localparam int SPRC_X_END   = 1;
  // ==========================================================
  // polling behaviours
  localparam logic [1:0] SPRC_MODE_COO  = 2'h0;
  localparam logic [1:0] SPRC_MODE_FFB  = 2'h1;
  localparam logic [1:0] SPRC_MODE_MM   = 2'h2;
  localparam logic [1:0] SPRC_MODE_PWUS = 2'h3;
  localparam int SPRC_CHAN_W = 8;
  typedef enum logic [2:0] {
    SPRC_IDLE, SPRC_SRCH_A, SPRC_SRCH_B, SPRC_OFF, SPRC_RUN_SYNC, SPRC_RUN_PAY
  } sprc_state_t;
endpackage

/* File: rtl/sprc_top.sv */
/*
  self polling run control: apb register file and the control machine
  sequencing wake-up search, off time and run state after wake-up.
  assumes polling timer, wake-up unit, framer, fifo and timeout timers
  live outside and talk through single-cycle event inputs.
*/
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
//
// Functional notes
// - operating select bit at one starts autonomous polling.
// - search config A, then B if dual; single mode uses A only.
// - wake-up raises optional alert and enters the run state.
// - run state demodulation follows the modulation type select bit.
// - run state waits for sync word, loads fifo, scans message ids.
// - masked alerts at frame start, message id and message end.
// - run left on timeouts, message end with return bit, or host mode change.
// - timeout returns to polling with next config or config A.
// - run state keeps taking further frames without new wake-up.
// - fifo cleared at run entry, or at sync word when not locked.
// - message end records channel and config in accepted record.
// - after message end: next config, config A, or reload timeouts.
// - external timeout and end commands accepted under external processing.
// - external command in last config before off time enters off time.
// - restart with A inits polling timer; next config keeps it.
// - constant on-off mode always inits polling timer after timeout or end.
// - parallel wake-up search during sync search, only after first payload.
// - parallel search runs from symbol sync until sync loss or wake-up.
// - external end returns to cycle start, reinits wake-up and timeouts.
// - framer keep bit skips framer register reset after wake-up.
// - hold only in slave run mode, never in autonomous polling.
// - two-bit field picks one of four polling behaviours.
module sprc_top
  import sprc_pkg::*;
#(
  parameter int CHAN_W = SPRC_CHAN_W
) (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              wakeup_found_i,
  input  wire logic              on_time_end_i,
  input  wire logic              off_time_end_i,
  input  wire logic              sync_word_found_i,
  input  wire logic              mid_found_i,
  input  wire logic              message_end_i,
  input  wire logic              sym_sync_i,
  input  wire logic              sync_lost_i,
  input  wire logic              fifo_locked_i,
  input  wire logic              sync_loss_timeout_i,
  input  wire logic              sync_word_timeout_i,
  input  wire logic              message_end_timeout_i,
  input  wire logic [CHAN_W-1:0] channel_i,
  output logic                   polling_o,
  output logic                   run_o,
  output logic                   config_b_o,
  output logic                   demod_run_o,
  output logic                   hold_o,
  output logic                   timer_init_o,
  output logic                   timeout_reload_o,
  output logic                   fifo_init_o,
  output logic                   framer_reset_o,
  output logic                   wakeup_reinit_o,
  output logic                   parallel_wu_o,
  output logic                   alert_wake_o,
  output logic                   alert_frame_o,
  output logic                   alert_mid_o,
  output logic                   alert_end_o
);
  initial begin
    if (CHAN_W < 1 || CHAN_W > 23) $error("channel width out of range");
  end
  // ==========================================================
  // state
  typedef struct packed {
    logic [SPRC_CTRL_W-1:0] ctrl;
    logic [3:0]             mask;
    sprc_state_t            st;
    logic                   cur_b;
    logic                   armed;
    logic                   pwu_act;
    logic                   sym_q;
    logic [CHAN_W:0]        rec;
    logic [31:0]            rdata;
    logic                   t_init;
    logic                   reload;
    logic                   f_init;
    logic                   fr_rst;
    logic                   wu_init;
    logic [3:0]             alert;
  } sprc_s_t;
  sprc_s_t r_reg;
  sprc_s_t r_next;
  logic acc;
  logic addr_ok;
  logic ext_to;
  logic ext_end;
  logic in_run;
  assign acc     = psel_i & penable_i;
  assign addr_ok = paddr_i inside {SPRC_OFF_CTRL, SPRC_OFF_MASK, SPRC_OFF_EXTCMD,
                                   SPRC_OFF_STATUS, SPRC_OFF_ACCEPT};
  assign in_run  = (r_reg.st == SPRC_RUN_SYNC) || (r_reg.st == SPRC_RUN_PAY);
  // ==========================================================
  // helpers
  // leave the run state toward next config, config a or the off time
  function automatic sprc_s_t f_leave(input sprc_s_t s, input logic rst_a);
    sprc_s_t o;
    logic    constant_on_off_polling;
    o   = s;
    constant_on_off_polling = (s.ctrl[SPRC_B_MODE_LO +: 2] == SPRC_MODE_COO);
    o.pwu_act = 1'b0;
    if (rst_a) begin
      o.st     = SPRC_SRCH_A;
      o.cur_b  = 1'b0;
      o.t_init = 1'b1;
    end else if (!s.cur_b && s.ctrl[SPRC_B_DUAL]) begin
      o.st     = SPRC_SRCH_B;
      o.cur_b  = 1'b1;
      o.t_init = constant_on_off_polling;
    end else begin
      // last config before the off time: go straight into it
      o.st     = (s.ctrl[SPRC_B_MODE_LO +: 2] == SPRC_MODE_PWUS) ? SPRC_SRCH_A : SPRC_OFF;
      o.cur_b  = 1'b0;
      o.t_init = constant_on_off_polling || (s.ctrl[SPRC_B_MODE_LO +: 2] == SPRC_MODE_PWUS);
    end
    return o;
  endfunction
  // cycle start of the run state
  function automatic sprc_s_t f_enter(input sprc_s_t s);
    sprc_s_t o;
    o = s;
    o.st      = SPRC_RUN_SYNC;
    o.f_init  = !s.ctrl[SPRC_B_FIFO_FRM];
    o.fr_rst  = !s.ctrl[SPRC_B_FR_KEEP];
    o.alert[SPRC_M_WAKE] = s.mask[SPRC_M_WAKE];
    o.armed   = 1'b0;
    o.pwu_act = 1'b0;
    return o;
  endfunction
  // ==========================================================
  // next state
  always_comb begin
    r_next = r_reg;
    r_next.t_init  = 1'b0;
    r_next.reload  = 1'b0;
    r_next.f_init  = 1'b0;
    r_next.fr_rst  = 1'b0;
    r_next.wu_init = 1'b0;
    r_next.alert   = 4'h0;
    r_next.sym_q   = sym_sync_i;
    ext_to  = 1'b0;
    ext_end = 1'b0;
    if (acc && pwrite_i) begin
      case (paddr_i)
        SPRC_OFF_EXTCMD: begin
          // commands only count while external processing owns the blocks
          ext_to  = pwdata_i[SPRC_X_TO] & r_reg.ctrl[SPRC_B_EXT_PROC];
          ext_end = pwdata_i[SPRC_X_END] & r_reg.ctrl[SPRC_B_EXT_PROC];
        end
        default: ;
      endcase
    end
    if (psel_i && !penable_i) begin
      case (paddr_i)
        SPRC_OFF_CTRL:   r_next.rdata = 32'(r_reg.ctrl);
        SPRC_OFF_MASK:   r_next.rdata = 32'(r_reg.mask);
        SPRC_OFF_STATUS: r_next.rdata = {24'h000000, r_reg.pwu_act, r_reg.armed,
                                         r_reg.cur_b, 2'h0, r_reg.st};
        SPRC_OFF_ACCEPT: r_next.rdata = 32'(r_reg.rec);
        default:         r_next.rdata = 32'h00000000;
      endcase
    end
    // settings are read live; the host keeps them still outside sleep
    if (!r_reg.ctrl[SPRC_B_OPSEL] || r_reg.ctrl[SPRC_B_SLEEP]) begin
      r_next.st      = SPRC_IDLE;
      r_next.cur_b   = 1'b0;
      r_next.pwu_act = 1'b0;
    end else begin
      case (r_reg.st)
        SPRC_IDLE: begin
          r_next.st     = SPRC_SRCH_A;
          r_next.cur_b  = 1'b0;
          r_next.t_init = 1'b1;
        end
        SPRC_SRCH_A: begin
          if (wakeup_found_i) begin
            r_next = f_enter(r_next);
          end else if (on_time_end_i) begin
            if (r_reg.ctrl[SPRC_B_DUAL]) begin
              r_next.st    = SPRC_SRCH_B;
              r_next.cur_b = 1'b1;
            end else if (r_reg.ctrl[SPRC_B_MODE_LO +: 2] == SPRC_MODE_PWUS) begin
              r_next.t_init = 1'b1;
            end else begin
              r_next.st = SPRC_OFF;
            end
          end
        end
        SPRC_SRCH_B: begin
          if (wakeup_found_i) begin
            r_next = f_enter(r_next);
          end else if (on_time_end_i) begin
            r_next.cur_b  = 1'b0;
            r_next.st     = (r_reg.ctrl[SPRC_B_MODE_LO +: 2] == SPRC_MODE_PWUS) ?
                            SPRC_SRCH_A : SPRC_OFF;
            r_next.t_init = (r_reg.ctrl[SPRC_B_MODE_LO +: 2] == SPRC_MODE_PWUS);
          end
        end
        SPRC_OFF: begin
          if (off_time_end_i) begin
            r_next.st     = SPRC_SRCH_A;
            r_next.t_init = 1'b1;
          end
        end
        SPRC_RUN_SYNC: begin
          if (sync_word_found_i) begin
            r_next.st      = SPRC_RUN_PAY;
            r_next.alert[SPRC_M_FRAME] = r_reg.mask[SPRC_M_FRAME];
            r_next.f_init  = r_reg.ctrl[SPRC_B_FIFO_FRM] & !fifo_locked_i;
            r_next.pwu_act = 1'b0;
          end else if (sync_loss_timeout_i || sync_word_timeout_i || ext_to) begin
            r_next = f_leave(r_next, r_reg.ctrl[SPRC_B_TO_RST_A]);
          end else if (ext_end) begin
            if (r_reg.ctrl[SPRC_B_RET_END]) begin
              r_next = f_leave(r_next, r_reg.ctrl[SPRC_B_END_RST_A]);
            end else begin
              r_next.reload  = 1'b1;
              r_next.wu_init = 1'b1;
              r_next.f_init  = !r_reg.ctrl[SPRC_B_FIFO_FRM];
              r_next.pwu_act = 1'b0;
            end
          end else if (r_reg.pwu_act && wakeup_found_i) begin
            r_next = f_enter(r_next);
          end else if (r_reg.pwu_act && sync_lost_i) begin
            r_next.pwu_act = 1'b0;
          end else if (sym_sync_i && !r_reg.sym_q && r_reg.armed &&
                       r_reg.ctrl[SPRC_B_PWU_EN] && !r_reg.ctrl[SPRC_B_MODTYPE]) begin
            // same modulation only: the wake-up unit shares the demodulator
            r_next.pwu_act = 1'b1;
          end
        end
        SPRC_RUN_PAY: begin
          if (mid_found_i) begin
            r_next.alert[SPRC_M_MID] = r_reg.mask[SPRC_M_MID];
          end
          if (message_end_i || ext_end) begin
            r_next.rec   = {r_reg.cur_b, channel_i};
            r_next.alert[SPRC_M_END] = r_reg.mask[SPRC_M_END] & message_end_i;
            r_next.armed = 1'b1;
            if (r_reg.ctrl[SPRC_B_RET_END]) begin
              r_next = f_leave(r_next, r_reg.ctrl[SPRC_B_END_RST_A]);
            end else begin
              r_next.st      = SPRC_RUN_SYNC;
              r_next.reload  = 1'b1;
              r_next.wu_init = ext_end;
            end
          end else if (message_end_timeout_i || ext_to) begin
            r_next = f_leave(r_next, r_reg.ctrl[SPRC_B_TO_RST_A]);
          end
        end
        default: r_next.st = SPRC_IDLE;
      endcase
    end
    // settings land last, so the machine and its helpers act on the old ones
    if (acc && pwrite_i && (paddr_i == SPRC_OFF_CTRL)) begin
      r_next.ctrl = pwdata_i[SPRC_CTRL_W-1:0];
    end
    if (acc && pwrite_i && (paddr_i == SPRC_OFF_MASK)) begin
      r_next.mask = pwdata_i[3:0];
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      r_reg      <= '0;
      r_reg.ctrl <= SPRC_CTRL_RST;
      r_reg.mask <= SPRC_MASK_RST;
      r_reg.st   <= SPRC_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end
  // ==========================================================
  // outputs
  assign prdata_o         = r_reg.rdata;
  assign pready_o         = acc;
  assign pslverr_o        = acc & !addr_ok;
  assign polling_o        = (r_reg.st != SPRC_IDLE);
  assign run_o            = in_run;
  assign config_b_o       = r_reg.cur_b;
  assign demod_run_o      = in_run & r_reg.ctrl[SPRC_B_MODTYPE];
  assign hold_o           = r_reg.ctrl[SPRC_B_HOLD] & !r_reg.ctrl[SPRC_B_OPSEL];
  assign timer_init_o     = r_reg.t_init;
  assign timeout_reload_o = r_reg.reload;
  assign fifo_init_o      = r_reg.f_init;
  assign framer_reset_o   = r_reg.fr_rst;
  assign wakeup_reinit_o  = r_reg.wu_init;
  assign parallel_wu_o    = r_reg.pwu_act;
  assign alert_wake_o     = r_reg.alert[SPRC_M_WAKE];
  assign alert_frame_o    = r_reg.alert[SPRC_M_FRAME];
  assign alert_mid_o      = r_reg.alert[SPRC_M_MID];
  assign alert_end_o      = r_reg.alert[SPRC_M_END];
  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  polling_start_a: assert property ((r_reg.st == SPRC_IDLE) && r_reg.ctrl[SPRC_B_OPSEL]
    && !r_reg.ctrl[SPRC_B_SLEEP] |=> (r_reg.st == SPRC_SRCH_A) && timer_init_o)
    else $error("polling did not start");
  single_cfg_a: assert property (!r_reg.ctrl[SPRC_B_DUAL] && !run_o
    && r_reg.ctrl[SPRC_B_OPSEL] && !r_reg.ctrl[SPRC_B_SLEEP] |=> !config_b_o)
    else $error("config b used in single mode");
  wake_run_a: assert property ((r_reg.st inside {SPRC_SRCH_A, SPRC_SRCH_B})
    && wakeup_found_i && r_reg.ctrl[SPRC_B_OPSEL] && !r_reg.ctrl[SPRC_B_SLEEP]
    |=> run_o && (alert_wake_o == $past(r_reg.mask[SPRC_M_WAKE])))
    else $error("wake-up did not enter run");
  demod_sel_a: assert property ((r_reg.st inside {SPRC_SRCH_A, SPRC_SRCH_B})
    && wakeup_found_i && r_reg.ctrl[SPRC_B_OPSEL] && !r_reg.ctrl[SPRC_B_SLEEP]
    |=> demod_run_o == $past(r_reg.ctrl[SPRC_B_MODTYPE]))
    else $error("demodulation select wrong");
  host_exit_a: assert property (r_reg.ctrl[SPRC_B_SLEEP] |=> !run_o && !config_b_o)
    else $error("run not left on sleep");
  timeout_exit_a: assert property ((r_reg.st == SPRC_RUN_SYNC) && sync_word_timeout_i
    && !sync_word_found_i && r_reg.ctrl[SPRC_B_OPSEL] && !r_reg.ctrl[SPRC_B_SLEEP]
    |=> !run_o)
    else $error("sync word timeout ignored");
  fifo_lock_a: assert property ((r_reg.st == SPRC_RUN_SYNC) && sync_word_found_i
    && fifo_locked_i |=> !fifo_init_o)
    else $error("locked fifo cleared");
  record_a: assert property ((r_reg.st == SPRC_RUN_PAY) && message_end_i
    && r_reg.ctrl[SPRC_B_OPSEL] && !r_reg.ctrl[SPRC_B_SLEEP]
    |=> r_reg.rec == {$past(r_reg.cur_b), $past(channel_i)})
    else $error("accepted record not written");
  reload_a: assert property ((r_reg.st == SPRC_RUN_PAY) && message_end_i
    && !r_reg.ctrl[SPRC_B_RET_END] && r_reg.ctrl[SPRC_B_OPSEL] && !r_reg.ctrl[SPRC_B_SLEEP]
    |=> (r_reg.st == SPRC_RUN_SYNC) && timeout_reload_o)
    else $error("timeouts not reloaded");
  coo_init_a: assert property (run_o && !$past(r_reg.ctrl[SPRC_B_SLEEP])
    && (r_reg.ctrl[SPRC_B_MODE_LO +: 2] == SPRC_MODE_COO) && r_reg.ctrl[SPRC_B_OPSEL]
    && !r_reg.ctrl[SPRC_B_SLEEP] ##1 !run_o && polling_o |-> timer_init_o)
    else $error("polling timer not reinitialised");
  framer_keep_a: assert property (r_reg.ctrl[SPRC_B_FR_KEEP] |=> !framer_reset_o)
    else $error("framer reset despite keep");
  pwu_payload_a: assert property ((r_reg.st == SPRC_RUN_PAY) |-> !parallel_wu_o)
    else $error("parallel search in payload");
  cv_wake_c:  cover property (alert_wake_o ##[1:50] alert_frame_o);
  cv_end_c:   cover property (alert_end_o ##[1:50] alert_frame_o);
  cv_cfgb_c:  cover property (config_b_o && run_o);
  cv_pwu_c:   cover property (parallel_wu_o ##[1:50] alert_wake_o);
endmodule

/* File: verification/sprc_radio_model.sv */
/*
  far-side model of the radio units: turns a numbered request from the
  bench into a one-cycle event pulse on the matching event line.
  assumes requests change just after a rising edge of clock_i.
*/
`timescale 1ns/1ns
module sprc_radio_model (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       go_i,
  input  wire logic [3:0] sel_i,
  output logic      [9:0] ev_o
);
  // ==========================================================
  // event pulses
  // one cycle wide only when go_i is high for one cycle; a held request keeps the line high
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ev_o <= 10'h000;
    end else begin
      ev_o <= go_i ? (10'h001 << sel_i) : 10'h000;
    end
  end
endmodule

/* File: verification/test_sprc_top.sv */
/*
  self-checking bench of the self polling run control: apb tasks, event
  requests through the radio model, expected states from the control table.
  assumes zero-wait apb answers but waits on pready under a bound.
*/
`timescale 1ns/1ns
module test_sprc_top;
  import sprc_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        go = 1'b0, clr = 1'b0, ssync = 1'b0, flock = 1'b0, err, pready, pslverr;
  logic [7:0]  paddr = 8'h00, chan = 8'h00;
  logic [8:0]  seen = 9'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [3:0]  sel = 4'h0;
  logic [9:0]  ev;
  logic        polling, run, cfg_b, demod, hold, tinit, reload, finit, frst, wre, pwu;
  logic        a_wake, a_frame, a_mid, a_end;
  int          miscompares = 0, n_checks = 0, cyc = 0;
  // ==========================================================
  // clock, pulse capture, timeout
  always #25 clk = ~clk;
  // pulses last one cycle, so they are latched here and looked at later
  always @(posedge clk) seen <= clr ? 9'h000 : seen | {wre, a_end, a_mid, a_frame, a_wake,
                                                      frst, finit, reload, tinit};
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  sprc_radio_model model (.clock_i(clk), .rstn_i(rstn), .go_i(go), .sel_i(sel), .ev_o(ev));
  sprc_top dut (
    .clock_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .wakeup_found_i(ev[0]), .on_time_end_i(ev[1]),
    .off_time_end_i(ev[2]), .sync_word_found_i(ev[3]), .mid_found_i(ev[4]),
    .message_end_i(ev[5]), .sym_sync_i(ssync), .sync_lost_i(ev[6]), .fifo_locked_i(flock),
    .sync_loss_timeout_i(ev[7]), .sync_word_timeout_i(ev[8]),
    .message_end_timeout_i(ev[9]), .channel_i(chan), .polling_o(polling), .run_o(run),
    .config_b_o(cfg_b), .demod_run_o(demod), .hold_o(hold), .timer_init_o(tinit),
    .timeout_reload_o(reload), .fifo_init_o(finit), .framer_reset_o(frst),
    .wakeup_reinit_o(wre), .parallel_wu_o(pwu), .alert_wake_o(a_wake),
    .alert_frame_o(a_frame), .alert_mid_o(a_mid), .alert_end_o(a_end)
  );
  // ==========================================================
  // tasks
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    pwdata <= ~d;
  endtask
  task automatic evt(input logic [3:0] s);
    @(posedge clk);
    clr <= 1'b1;
    go <= 1'b1;
    sel <= s;
    @(posedge clk);
    clr <= 1'b0;
    go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic st(input logic [2:0] s);
    apb(1'b0, SPRC_OFF_STATUS, 32'h00000000);
    chk("state", {29'h0, s}, {29'h0, rd[2:0]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, SPRC_OFF_CTRL, 32'h00000000);
    chk("ctrl reset", 32'h00000002, rd);
    apb(1'b0, SPRC_OFF_MASK, 32'h00000000);
    chk("mask reset", 32'h00000000, rd);
    apb(1'b0, 8'h14, 32'h00000000);
    chkb("unmapped err", 1'b1, err);
    chk("unmapped data", 32'h00000000, rd);
    apb(1'b1, SPRC_OFF_MASK, 32'h0000000F);
    apb(1'b1, SPRC_OFF_CTRL, 32'h00000012);
    apb(1'b1, SPRC_OFF_CTRL, 32'h00000011);
    st(3'h1);
    chkb("polling", 1'b1, polling);
    evt(4'h1);
    st(3'h2);
    chkb("config b", 1'b1, cfg_b);
    evt(4'h1);
    st(3'h3);
    evt(4'h2);
    st(3'h1);
    chkb("timer init", 1'b1, seen[0]);
    evt(4'h0);
    chkb("run", 1'b1, run);
    chkb("fifo init entry", 1'b1, seen[2]);
    chkb("framer reset", 1'b1, seen[3]);
    chkb("wake alert", 1'b1, seen[4]);
    evt(4'h3);
    st(3'h5);
    chkb("frame alert", 1'b1, seen[5]);
    chkb("no fifo init", 1'b0, seen[2]);
    evt(4'h4);
    chkb("mid alert", 1'b1, seen[6]);
    chan <= 8'h5A;
    evt(4'h5);
    chkb("end alert", 1'b1, seen[7]);
    chkb("reload", 1'b1, seen[1]);
    st(3'h4);
    apb(1'b0, SPRC_OFF_ACCEPT, 32'h00000000);
    chk("accept", 32'h0000005A, rd);
    evt(4'h8);
    chkb("init after timeout", 1'b1, seen[0]);
    st(3'h2);
    apb(1'b1, SPRC_OFF_CTRL, 32'h00002002);
    repeat (2) @(posedge clk);
    chkb("hold slave", 1'b1, hold);
    apb(1'b1, SPRC_OFF_CTRL, 32'h00002261);
    repeat (2) @(posedge clk);
    chkb("hold polling", 1'b0, hold);
    evt(4'h1);
    st(3'h3);
    evt(4'h2);
    evt(4'h0);
    chkb("demod", 1'b1, demod);
    apb(1'b1, SPRC_OFF_EXTCMD, 32'h00000001);
    st(3'h3);
    evt(4'h2);
    evt(4'h0);
    evt(4'h3);
    evt(4'h5);
    st(3'h3);
    evt(4'h2);
    evt(4'h0);
    apb(1'b1, SPRC_OFF_CTRL, 32'h00002262);
    st(3'h0);
    apb(1'b1, SPRC_OFF_CTRL, 32'h0000000E);
    apb(1'b1, SPRC_OFF_CTRL, 32'h0000000D);
    evt(4'h1);
    st(3'h1);
    chkb("pwus init", 1'b1, seen[0]);
    // ==========================================================
    // fast fall back, dual, parallel search, frame-start fifo, external end
    apb(1'b1, SPRC_OFF_CTRL, 32'h00001296);
    apb(1'b1, SPRC_OFF_CTRL, 32'h00001295);
    evt(4'h0);
    chkb("no fifo at entry", 1'b0, seen[2]);
    flock <= 1'b1;
    evt(4'h3);
    chkb("locked fifo kept", 1'b0, seen[2]);
    chkb("frame alert b12", 1'b1, seen[5]);
    flock <= 1'b0;
    evt(4'h5);
    st(3'h4);
    ssync <= 1'b1;
    repeat (2) @(posedge clk);
    chkb("pwu on", 1'b1, pwu);
    evt(4'h6);
    chkb("pwu off on loss", 1'b0, pwu);
    ssync <= 1'b0;
    @(posedge clk);
    ssync <= 1'b1;
    repeat (2) @(posedge clk);
    chkb("pwu on again", 1'b1, pwu);
    evt(4'h0);
    chkb("parallel wake alert", 1'b1, seen[4]);
    chkb("pwu off on wake", 1'b0, pwu);
    chkb("run kept", 1'b1, run);
    evt(4'hA); // no event line: only clears the capture
    apb(1'b1, SPRC_OFF_EXTCMD, 32'h00000002);
    apb(1'b1, SPRC_OFF_EXTCMD, 32'h00000002);
    chkb("wake reinit", 1'b1, seen[8]);
    chkb("ext end reload", 1'b1, seen[1]);
    st(3'h4);
    evt(4'h3);
    chkb("fifo at frame", 1'b1, seen[2]);
    evt(4'h9);
    chkb("ffb keeps timer", 1'b0, seen[0]);
    st(3'h2);
    chkb("config b next", 1'b1, cfg_b);
    evt(4'h0);
    evt(4'h3);
    chan <= 8'hC3;
    evt(4'h5);
    apb(1'b0, SPRC_OFF_ACCEPT, 32'h00000000);
    chk("accept b", 32'h000001C3, rd);
    evt(4'h7);
    st(3'h3);
    chkb("ffb off no init", 1'b0, seen[0]);
    chkb("config a after b", 1'b0, cfg_b);
    print_verdict();
  end
endmodule
